// [verilog/com_defines.svh]
`ifndef COM_DEFINES_SVH
`define COM_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define COM_NUM_LP 2
`define COM_LP_W 1
`define COM_TAG_W 10
`define COM_NUM_TAGS 1024
`define COM_CNT_W 20
`define COM_CNT_ONE 20'h00001
`define COM_CNT_MAX 20'hfffff

// ----------------------------------------
// System register indices
// ----------------------------------------
`define COM_IDX_ACTIVE_TAG 32'h0000_0c8f
`define COM_IDX_EVT_SEL 32'h0000_0c8d
`define COM_IDX_RESULT 32'h0000_0c8e

// ----------------------------------------
// Field layout
// ----------------------------------------
`define COM_EVT_HI 7
`define COM_EVT_LO 0
`define COM_ETAG_HI 41
`define COM_ETAG_LO 32
`define COM_ETAG_RSV_HI 63
`define COM_ETAG_RSV_LO 42
`define COM_ERR_BIT 63
`define COM_UNAV_BIT 62
`define COM_DATA_W 62
`define COM_EVT_L3_OCC 8'h01

// ----------------------------------------
// Enumeration
// ----------------------------------------
`define COM_LEAF_BASE 32'h0000_0000
`define COM_LEAF_FEAT 32'h0000_0007
`define COM_LEAF_MON 32'h0000_000f
`define COM_SUB_RES 32'h0000_0000
`define COM_SUB_L3 32'h0000_0001
`define COM_HIGHEST_LEAF 32'h0000_000f
`define COM_FEAT_BIT 12
`define COM_L3_RES_BIT 1
`define COM_MAX_TAG 32'h0000_03ff
`define COM_CONV_FACTOR 32'h0000_0040
`define COM_EVT_VEC 32'h0000_0001

`endif

// [verilog/com_pkg.sv]
package com_pkg;

  // Register selected by a system register index
  typedef enum logic [1:0] {
    com_sel_none,
    com_sel_tag,
    com_sel_evt,
    com_sel_res
  } com_reg_sel_t;

endpackage : com_pkg

// [verilog/com_occ_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "com_defines.svh"

// Link between the register front end and the occupancy table
interface com_occ_if;
  logic fill_valid;
  logic [`COM_TAG_W-1:0] fill_tag;
  logic evict_valid;
  logic [`COM_TAG_W-1:0] evict_tag;
  logic [`COM_TAG_W-1:0] rd_tag;
  logic [`COM_CNT_W-1:0] rd_count;
  logic rd_seen;

  modport table_side (
    input fill_valid, fill_tag, evict_valid, evict_tag, rd_tag,
    output rd_count, rd_seen
  );
  modport ctrl_side (
    output fill_valid, fill_tag, evict_valid, evict_tag, rd_tag,
    input rd_count, rd_seen
  );
endinterface : com_occ_if

`default_nettype wire

// [verilog/com_occ_table.sv]
`timescale 1ns/1ps
`default_nettype none
`include "com_defines.svh"

module com_occ_table (
  input wire logic ref_clk,
  input wire logic rst_n,
  com_occ_if.table_side occ
);

  logic [`COM_CNT_W-1:0] cnt_mem [`COM_NUM_TAGS];
  logic [`COM_NUM_TAGS-1:0] seen_r;
  logic same_tag;

  // ----------------------------------------
  // Per-tag line counters
  // ----------------------------------------
  // Fill and evict of one tag in one cycle cancel out
  assign same_tag = occ.fill_valid && occ.evict_valid && (occ.fill_tag == occ.evict_tag);

  // Only seen bits are reset; a counter is trusted once its tag is seen
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen_r <= '0;
    end else if (occ.fill_valid && !same_tag) begin
      seen_r[occ.fill_tag] <= 1'b1;
    end
  end

  // Counters saturate, so a stray evict cannot wrap to a huge figure
  always_ff @(posedge ref_clk) begin
    if (rst_n && !same_tag) begin
      if (occ.fill_valid) begin
        if (!seen_r[occ.fill_tag]) begin
          cnt_mem[occ.fill_tag] <= `COM_CNT_ONE;
        end else if (cnt_mem[occ.fill_tag] != `COM_CNT_MAX) begin
          cnt_mem[occ.fill_tag] <= cnt_mem[occ.fill_tag] + `COM_CNT_ONE;
        end
      end
      if (occ.evict_valid && seen_r[occ.evict_tag] && cnt_mem[occ.evict_tag] != '0) begin
        cnt_mem[occ.evict_tag] <= cnt_mem[occ.evict_tag] - `COM_CNT_ONE;
      end
    end
  end

  // Lookup for the result register
  assign occ.rd_seen = seen_r[occ.rd_tag];
  assign occ.rd_count = seen_r[occ.rd_tag] ? cnt_mem[occ.rd_tag] : '0;

endmodule : com_occ_table

`default_nettype wire

// [verilog/com_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "com_defines.svh"

module com_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sys_reg_read_op,
  input wire logic sys_reg_write_op,
  input wire logic [`COM_LP_W-1:0] sys_reg_lp,
  input wire logic [31:0] sys_reg_index,
  input wire logic [63:0] sys_reg_wdata,
  output logic [63:0] sys_reg_rdata_r,
  output logic sys_reg_done_r,
  output logic sys_reg_fault_r,
  input wire logic enum_req,
  input wire logic [31:0] enum_leaf,
  input wire logic [31:0] enum_subleaf,
  output logic [31:0] enum_eax_r,
  output logic [31:0] enum_ebx_r,
  output logic [31:0] enum_ecx_r,
  output logic [31:0] enum_edx_r,
  output logic enum_done_r,
  input wire logic cache_req_valid,
  input wire logic [`COM_LP_W-1:0] cache_req_lp,
  output logic tagged_req_valid_r,
  output logic [`COM_TAG_W-1:0] tagged_req_tag_r,
  input wire logic l3_fill_valid,
  input wire logic [`COM_TAG_W-1:0] l3_fill_tag,
  input wire logic l3_evict_valid,
  input wire logic [`COM_TAG_W-1:0] l3_evict_tag
);

  // ----------------------------------------
  // Index decode
  // ----------------------------------------
  // Shared by the read and the write path
  function automatic com_pkg::com_reg_sel_t reg_sel(input logic [31:0] idx);
    com_pkg::com_reg_sel_t s;
    s = com_pkg::com_sel_none;
    if (idx == `COM_IDX_ACTIVE_TAG) begin
      s = com_pkg::com_sel_tag;
    end else if (idx == `COM_IDX_EVT_SEL) begin
      s = com_pkg::com_sel_evt;
    end else if (idx == `COM_IDX_RESULT) begin
      s = com_pkg::com_sel_res;
    end
    return s;
  endfunction : reg_sel

  com_pkg::com_reg_sel_t wr_sel;
  com_pkg::com_reg_sel_t rd_sel;
  logic wr_hit;

  // No memory-mapped path exists; these ops are the only way in
  assign wr_sel = reg_sel(sys_reg_index);
  assign rd_sel = reg_sel(sys_reg_index);
  assign wr_hit = sys_reg_write_op && !sys_reg_read_op;

  // ----------------------------------------
  // Per logical processor registers
  // ----------------------------------------
  logic [`COM_NUM_LP*`COM_TAG_W-1:0] active_tag_flat;
  logic [`COM_NUM_LP*8-1:0] evt_code_flat;
  logic [`COM_NUM_LP*`COM_TAG_W-1:0] evt_tag_flat;
  logic [`COM_NUM_LP-1:0] evt_tag_over_flat;

  genvar g;
  generate
    for (g = 0; g < `COM_NUM_LP; g++) begin : g_lp
      logic [`COM_TAG_W-1:0] tag_r;
      logic [7:0] evt_code_r;
      logic [`COM_TAG_W-1:0] evt_tag_r;
      logic evt_tag_over_r;
      logic lane_wr;

      // Each lane answers only to writes aimed at its own processor
      assign lane_wr = wr_hit && (sys_reg_lp == `COM_LP_W'(g));

      // Active tag: one value per lane, replaced whole on write
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          tag_r <= '0;
        end else if (lane_wr && wr_sel == com_pkg::com_sel_tag) begin
          tag_r <= sys_reg_wdata[`COM_TAG_W-1:0];
        end
      end

      // Event select; reserved tag bits are kept only as an overrange mark
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          evt_code_r <= '0;
          evt_tag_r <= '0;
          evt_tag_over_r <= 1'b0;
        end else if (lane_wr && wr_sel == com_pkg::com_sel_evt) begin
          evt_code_r <= sys_reg_wdata[`COM_EVT_HI:`COM_EVT_LO];
          evt_tag_r <= sys_reg_wdata[`COM_ETAG_HI:`COM_ETAG_LO];
          evt_tag_over_r <= |sys_reg_wdata[`COM_ETAG_RSV_HI:`COM_ETAG_RSV_LO];
        end
      end

      assign active_tag_flat[g*`COM_TAG_W +: `COM_TAG_W] = tag_r;
      assign evt_code_flat[g*8 +: 8] = evt_code_r;
      assign evt_tag_flat[g*`COM_TAG_W +: `COM_TAG_W] = evt_tag_r;
      assign evt_tag_over_flat[g] = evt_tag_over_r;
    end
  endgenerate

  // ----------------------------------------
  // Tagging of cache requests
  // ----------------------------------------
  // Each request leaves one cycle later stamped with its issuer's tag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tagged_req_valid_r <= 1'b0;
      tagged_req_tag_r <= '0;
    end else begin
      tagged_req_valid_r <= cache_req_valid;
      tagged_req_tag_r <= active_tag_flat[cache_req_lp*`COM_TAG_W +: `COM_TAG_W];
    end
  end

  // ----------------------------------------
  // Occupancy table
  // ----------------------------------------
  com_occ_if occ ();

  // The table is shared by all lanes, so any active tag can be queried
  assign occ.fill_valid = l3_fill_valid;
  assign occ.fill_tag = l3_fill_tag;
  assign occ.evict_valid = l3_evict_valid;
  assign occ.evict_tag = l3_evict_tag;
  assign occ.rd_tag = evt_tag_flat[sys_reg_lp*`COM_TAG_W +: `COM_TAG_W];

  com_occ_table u_table (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .occ (occ)
  );

  // ----------------------------------------
  // Result word
  // ----------------------------------------
  logic [7:0] sel_code;
  logic sel_over;
  logic res_err;
  logic res_unav;
  logic [63:0] res_word;

  // Built from live event select at read time, never stored
  assign sel_code = evt_code_flat[sys_reg_lp*8 +: 8];
  assign sel_over = evt_tag_over_flat[sys_reg_lp];
  assign res_err = (sel_code != `COM_EVT_L3_OCC) || sel_over;
  assign res_unav = !res_err && !occ.rd_seen;

  // Data forced to zero whenever either flag is up
  always_comb begin
    res_word = '0;
    res_word[`COM_ERR_BIT] = res_err;
    res_word[`COM_UNAV_BIT] = res_unav;
    if (!res_err && !res_unav) begin
      res_word[`COM_DATA_W-1:0] = {{(`COM_DATA_W-`COM_CNT_W){1'b0}}, occ.rd_count};
    end
  end

  // ----------------------------------------
  // System register answer
  // ----------------------------------------
  logic [63:0] rd_word;
  logic rd_known;

  // Reserved bits read as zero
  always_comb begin
    rd_word = '0;
    rd_known = 1'b1;
    case (rd_sel)
      com_pkg::com_sel_tag: begin
        rd_word[`COM_TAG_W-1:0] = active_tag_flat[sys_reg_lp*`COM_TAG_W +: `COM_TAG_W];
      end
      com_pkg::com_sel_evt: begin
        rd_word[`COM_EVT_HI:`COM_EVT_LO] = sel_code;
        rd_word[`COM_ETAG_HI:`COM_ETAG_LO] = occ.rd_tag;
      end
      com_pkg::com_sel_res: begin
        rd_word = res_word;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  // One-cycle answer; a write to the result word is dropped silently
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sys_reg_rdata_r <= '0;
      sys_reg_done_r <= 1'b0;
      sys_reg_fault_r <= 1'b0;
    end else begin
      sys_reg_done_r <= sys_reg_read_op || sys_reg_write_op;
      sys_reg_rdata_r <= '0;
      sys_reg_fault_r <= 1'b0;
      if (sys_reg_read_op) begin
        sys_reg_rdata_r <= rd_word;
        sys_reg_fault_r <= !rd_known;
      end else if (sys_reg_write_op) begin
        sys_reg_fault_r <= (wr_sel == com_pkg::com_sel_none);
      end
    end
  end

  // ----------------------------------------
  // Capability enumeration
  // ----------------------------------------
  logic [31:0] e_eax;
  logic [31:0] e_ebx;
  logic [31:0] e_ecx;
  logic [31:0] e_edx;

  // Unknown leaves answer all zero
  always_comb begin
    e_eax = '0;
    e_ebx = '0;
    e_ecx = '0;
    e_edx = '0;
    if (enum_leaf == `COM_LEAF_BASE) begin
      e_eax = `COM_HIGHEST_LEAF;
    end else if (enum_leaf == `COM_LEAF_FEAT && enum_subleaf == '0) begin
      e_ebx[`COM_FEAT_BIT] = 1'b1;
    end else if (enum_leaf == `COM_LEAF_MON && enum_subleaf == `COM_SUB_RES) begin
      e_ebx = `COM_MAX_TAG;
      e_edx[`COM_L3_RES_BIT] = 1'b1;
    end else if (enum_leaf == `COM_LEAF_MON && enum_subleaf == `COM_SUB_L3) begin
      e_ebx = `COM_CONV_FACTOR;
      e_ecx = `COM_MAX_TAG;
      e_edx = `COM_EVT_VEC;
    end
  end

  // Registered answer one cycle after the query
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enum_eax_r <= '0;
      enum_ebx_r <= '0;
      enum_ecx_r <= '0;
      enum_edx_r <= '0;
      enum_done_r <= 1'b0;
    end else begin
      enum_done_r <= enum_req;
      if (enum_req) begin
        enum_eax_r <= e_eax;
        enum_ebx_r <= e_ebx;
        enum_ecx_r <= e_ecx;
        enum_edx_r <= e_edx;
      end
    end
  end

endmodule : com_monitor

`default_nettype wire

// [bench/com_monitor_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "com_defines.svh"

// ----------------------------------------
// Port checks of the monitor
// ----------------------------------------
module com_monitor_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sys_reg_read_op,
  input wire logic sys_reg_write_op,
  input wire logic [`COM_LP_W-1:0] sys_reg_lp,
  input wire logic [31:0] sys_reg_index,
  input wire logic [63:0] sys_reg_wdata,
  input wire logic [63:0] sys_reg_rdata_r,
  input wire logic sys_reg_done_r,
  input wire logic sys_reg_fault_r,
  input wire logic enum_req,
  input wire logic enum_done_r,
  input wire logic cache_req_valid,
  input wire logic tagged_req_valid_r,
  input wire logic [`COM_TAG_W-1:0] tagged_req_tag_r
);
  logic any_op_w;
  logic mapped_w;
  logic tag_set_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Request decode shared by several checks
  assign any_op_w = sys_reg_read_op || sys_reg_write_op;
  assign mapped_w = sys_reg_index == `COM_IDX_ACTIVE_TAG || sys_reg_index == `COM_IDX_EVT_SEL
    || sys_reg_index == `COM_IDX_RESULT;

  // Conservative: any tag write ends the all-zero period
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tag_set_r <= 1'b0;
    end else if (sys_reg_write_op && !sys_reg_read_op && sys_reg_index == `COM_IDX_ACTIVE_TAG) begin
      tag_set_r <= 1'b1;
    end
  end

  a_done_after_op: assert property (any_op_w |=> sys_reg_done_r)
    else $error("register access not completed one cycle later");
  a_fault_unmapped: assert property (any_op_w && !mapped_w |=> sys_reg_fault_r
    && sys_reg_rdata_r == 64'h0) else $error("unmapped access without fault");
  a_rdata_idle: assert property (!sys_reg_done_r |-> sys_reg_rdata_r == 64'h0
    && !sys_reg_fault_r) else $error("read data or fault outside completion");
  a_enum_done: assert property (enum_req |=> enum_done_r)
    else $error("enumeration answer missing");
  a_tag_pass: assert property (cache_req_valid |=> tagged_req_valid_r)
    else $error("cache request not tagged");
  a_tag_zero_unset: assert property (cache_req_valid && !tag_set_r |=>
    tagged_req_tag_r == 10'h0) else $error("nonzero tag before any tag write");
  a_tag_write_read: assert property (sys_reg_write_op && !sys_reg_read_op
    && sys_reg_index == `COM_IDX_ACTIVE_TAG ##1 !sys_reg_write_op ##1 sys_reg_read_op
    && sys_reg_index == `COM_IDX_ACTIVE_TAG && sys_reg_lp == $past(sys_reg_lp, 2)
    |=> sys_reg_rdata_r == ($past(sys_reg_wdata, 3) & 64'h3ff))
    else $error("active tag read differs from last write");
  a_evt_code_err: assert property (sys_reg_write_op && !sys_reg_read_op
    && sys_reg_index == `COM_IDX_EVT_SEL && sys_reg_wdata[7:0] != 8'h01 ##1 !sys_reg_write_op
    ##1 sys_reg_read_op && sys_reg_index == `COM_IDX_RESULT && sys_reg_lp == $past(sys_reg_lp, 2)
    |=> sys_reg_rdata_r[63]) else $error("unsupported event code without error flag");
  a_result_fields: assert property (sys_reg_read_op && sys_reg_index == `COM_IDX_RESULT
    |=> !(sys_reg_rdata_r[63] && sys_reg_rdata_r[62])
    && (sys_reg_rdata_r[63:62] == 2'h0 || sys_reg_rdata_r[61:0] == 62'h0))
    else $error("result flags and data inconsistent");
endmodule : com_monitor_assertions

bind com_monitor com_monitor_assertions i_com_monitor_assertions (.ref_clk, .rst_n,
  .sys_reg_read_op, .sys_reg_write_op, .sys_reg_lp, .sys_reg_index, .sys_reg_wdata,
  .sys_reg_rdata_r, .sys_reg_done_r, .sys_reg_fault_r, .enum_req, .enum_done_r,
  .cache_req_valid, .tagged_req_valid_r, .tagged_req_tag_r);

`default_nettype wire

// [bench/test_com_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "com_defines.svh"
`define CHK(n, e, g) check_val(n, 64'(e), 64'(g));

// ----------------------------------------
// Self-checking bench of the monitor
// ----------------------------------------
module test_com_monitor;
  typedef struct {
    logic rd;
    logic [`COM_LP_W-1:0] lp;
    logic [31:0] idx;
    logic [63:0] wd;
    logic [63:0] ex;
    logic fl;
  } com_tb_row_t;
  localparam logic [31:0] idx_tag = `COM_IDX_ACTIVE_TAG;
  localparam logic [31:0] idx_evt = `COM_IDX_EVT_SEL;
  localparam logic [31:0] idx_res = `COM_IDX_RESULT;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic sys_reg_read_op = 1'b0, sys_reg_write_op = 1'b0, enum_req = 1'b0;
  logic cache_req_valid = 1'b0, l3_fill_valid = 1'b0, l3_evict_valid = 1'b0;
  logic [`COM_LP_W-1:0] sys_reg_lp = '0, cache_req_lp = '0;
  logic [31:0] sys_reg_index = 32'h0, enum_leaf = 32'h0, enum_subleaf = 32'h0;
  logic [63:0] sys_reg_wdata = 64'h0, sys_reg_rdata_r;
  logic sys_reg_done_r, sys_reg_fault_r, enum_done_r, tagged_req_valid_r;
  logic [31:0] enum_eax_r, enum_ebx_r, enum_ecx_r, enum_edx_r;
  logic [`COM_TAG_W-1:0] l3_fill_tag = 10'h0, l3_evict_tag = 10'h0, tagged_req_tag_r;
  int bad_count = 0, check_count = 0;
  // Ordinary accesses: read flag, lane, index, write data, expected data, expected fault
  com_tb_row_t rows [20] = '{
    '{1'b1, 1'b0, idx_tag, 64'h0, 64'h0, 1'b0},
    '{1'b0, 1'b0, idx_tag, 64'h155, 64'h0, 1'b0},
    '{1'b0, 1'b1, idx_tag, 64'h155, 64'h0, 1'b0},
    '{1'b1, 1'b1, idx_tag, 64'h0, 64'h155, 1'b0},
    '{1'b0, 1'b1, idx_tag, 64'h3ff, 64'h0, 1'b0},
    '{1'b1, 1'b1, idx_tag, 64'h0, 64'h3ff, 1'b0},
    '{1'b1, 1'b0, idx_tag, 64'h0, 64'h155, 1'b0},
    '{1'b1, 1'b0, idx_res, 64'h0, 64'h8000_0000_0000_0000, 1'b0},
    '{1'b0, 1'b0, idx_evt, 64'h0000_0155_0000_0001, 64'h0, 1'b0},
    '{1'b1, 1'b0, idx_evt, 64'h0, 64'h0000_0155_0000_0001, 1'b0},
    '{1'b1, 1'b0, idx_res, 64'h0, 64'h4000_0000_0000_0000, 1'b0},
    '{1'b0, 1'b0, idx_evt, 64'h0000_0155_0000_0002, 64'h0, 1'b0},
    '{1'b1, 1'b0, idx_res, 64'h0, 64'h8000_0000_0000_0000, 1'b0},
    '{1'b0, 1'b0, idx_evt, 64'h0000_0555_0000_0001, 64'h0, 1'b0},
    '{1'b1, 1'b0, idx_evt, 64'h0, 64'h0000_0155_0000_0001, 1'b0},
    '{1'b1, 1'b0, idx_res, 64'h0, 64'h8000_0000_0000_0000, 1'b0},
    '{1'b1, 1'b0, 32'h10, 64'h0, 64'h0, 1'b1},
    '{1'b0, 1'b0, 32'h10, 64'h1, 64'h0, 1'b1},
    '{1'b0, 1'b0, idx_res, 64'hffff_ffff_ffff_ffff, 64'h0, 1'b0},
    '{1'b1, 1'b0, idx_res, 64'h0, 64'h8000_0000_0000_0000, 1'b0}
  };

  com_monitor i_com_monitor (.ref_clk, .rst_n, .sys_reg_read_op, .sys_reg_write_op,
    .sys_reg_lp, .sys_reg_index, .sys_reg_wdata, .sys_reg_rdata_r, .sys_reg_done_r,
    .sys_reg_fault_r, .enum_req, .enum_leaf, .enum_subleaf, .enum_eax_r, .enum_ebx_r,
    .enum_ecx_r, .enum_edx_r, .enum_done_r, .cache_req_valid, .cache_req_lp,
    .tagged_req_valid_r, .tagged_req_tag_r, .l3_fill_valid, .l3_fill_tag,
    .l3_evict_valid, .l3_evict_tag);

  // 50 ns period
  initial forever #25 ref_clk = ~ref_clk;

  task automatic check_val(string n, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check_val

  // One access; released at the taking edge so the next call never overlaps it
  task automatic reg_op(logic rd, logic [`COM_LP_W-1:0] lp, logic [31:0] idx, logic [63:0] wd);
    @(posedge ref_clk);
    sys_reg_read_op <= rd;
    sys_reg_write_op <= !rd;
    sys_reg_lp <= lp;
    sys_reg_index <= idx;
    sys_reg_wdata <= wd;
    @(posedge ref_clk);
    sys_reg_read_op <= 1'b0;
    sys_reg_write_op <= 1'b0;
    #1;
  endtask : reg_op

  task automatic enum_q(logic [31:0] leaf, logic [31:0] sub);
    @(posedge ref_clk);
    enum_req <= 1'b1;
    enum_leaf <= leaf;
    enum_subleaf <= sub;
    @(posedge ref_clk);
    enum_req <= 1'b0;
    #1;
    `CHK("enum done", 1'b1, enum_done_r)
  endtask : enum_q

  // Fill and evict pulses for one tag
  task automatic occ(logic f, logic e, logic [`COM_TAG_W-1:0] t);
    @(posedge ref_clk);
    l3_fill_valid <= f;
    l3_evict_valid <= e;
    l3_fill_tag <= t;
    l3_evict_tag <= t;
    @(posedge ref_clk);
    l3_fill_valid <= 1'b0;
    l3_evict_valid <= 1'b0;
  endtask : occ

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is about a hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      reg_op(rows[i].rd, rows[i].lp, rows[i].idx, rows[i].wd);
      `CHK("done", 1'b1, sys_reg_done_r)
      `CHK("fault", rows[i].fl, sys_reg_fault_r)
      `CHK("rdata", rows[i].ex, sys_reg_rdata_r)
    end
    // Each lane's cache request carries its own tag
    for (int l = 0; l < 2; l++) begin
      @(posedge ref_clk);
      cache_req_valid <= 1'b1;
      cache_req_lp <= l[0:0];
      @(posedge ref_clk);
      cache_req_valid <= 1'b0;
      #1;
      `CHK("tag valid", 1'b1, tagged_req_valid_r)
      `CHK("tag", (l == 1) ? 10'h3ff : 10'h155, tagged_req_tag_r)
    end
    // Three fills, a cancelling pair, one evict: two lines left
    repeat (3) occ(1'b1, 1'b0, 10'h3ff);
    occ(1'b1, 1'b1, 10'h3ff);
    occ(1'b0, 1'b1, 10'h3ff);
    reg_op(1'b0, 1'b0, idx_evt, 64'h0000_03ff_0000_0001);
    reg_op(1'b1, 1'b0, idx_res, 64'h0);
    `CHK("count of other lane tag", 64'h2, sys_reg_rdata_r)
    repeat (3) occ(1'b0, 1'b1, 10'h3ff);
    reg_op(1'b1, 1'b0, idx_res, 64'h0);
    `CHK("emptied count", 64'h0, sys_reg_rdata_r)
    enum_q(32'h0, 32'h0);
    `CHK("highest leaf", 32'hf, enum_eax_r)
    enum_q(32'h7, 32'h0);
    `CHK("feature flag", 1'b1, enum_ebx_r[12])
    enum_q(32'hf, 32'h0);
    `CHK("highest tag", 32'h3ff, enum_ebx_r)
    `CHK("resource l3", 1'b1, enum_edx_r[1])
    enum_q(32'hf, 32'h1);
    `CHK("factor", 32'h40, enum_ebx_r)
    `CHK("l3 highest tag", 32'h3ff, enum_ecx_r)
    `CHK("event vector", 32'h1, enum_edx_r)
    enum_q(32'h5, 32'h0);
    `CHK("unknown leaf", 32'h0, enum_eax_r | enum_ebx_r | enum_ecx_r | enum_edx_r)
    // Reset in mid-run clears tags and event select
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_op(1'b1, 1'b1, idx_tag, 64'h0);
    `CHK("tag after reset", 64'h0, sys_reg_rdata_r)
    reg_op(1'b1, 1'b0, idx_res, 64'h0);
    `CHK("result after reset", 64'h8000_0000_0000_0000, sys_reg_rdata_r)
    report_and_stop();
  end
endmodule : test_com_monitor

`default_nettype wire
